/* File: logic/dfal_alert_top.sv */
/*
  Diagnostic flag collection and alert generation: flag register,
  per-flag alert enables, alert pin, forced diagnostic state on the
  high-speed outputs, write lock, watchdog, oscillator monitor and
  error correction of shadow register and memory words.
  Assumes the serial protocol engine supplies configuration writes
  and transfer result strobes on ref_clk, and the analog checks give
  asynchronous fault levels.
*/
// Function
// RL1 - I2C interrupt mode turns select pin into alert
// RL2 - Slave address is programmable
// RL3 - Host gives each shared device its own address
// RL4 - Write lock makes all further writes rejected
// RL5 - Each check sets its own readable flag
// RL6 - Each flag has its own alert enable
// RL7 - Alert can force high-speed outputs to diagnostic state
// RL8 - Output forcing has enable and low/high choice
// RL9 - Static flags clear only on power-on reset
// RL10 - Temporary flags clear when cause goes away
// RL11 - Continuous flags always, start-up flags once
// RL12 - Supply over/under-voltage flags, temporary, continuous
// RL13 - Failed serial transfer raises protocol flag
// RL14 - Shadow double-bit error sets static flag
// RL15 - Shadow single-bit error flagged and corrected
// RL16 - Memory double-bit error at start-up, static
// RL17 - Memory single-bit error at start-up, corrected
// RL18 - Oscillator frequency outside programmed range flagged
// RL19 - Stopped oscillator raises separate flag
// RL20 - Analog supply low or pin over-voltage shared flag
// RL21 - Low amplitude flagged in incremental mode
// RL22 - Watchdog expiry flags and restarts; zero stops
// RL23 - Alert pin low while enabled flag is set
`include "dfal_map.svh"

module dfal_alert_top (
  input  wire logic                     ref_clk,
  input  wire logic                     resetn,
  input  wire logic                     cfgWrite,
  input  wire dfal_pkg::dfal_cfg_s      cfgData,
  input  wire logic                     wdWrite,
  input  wire logic [`DFAL_WD_W-1:0]    wdValue,
  input  wire dfal_pkg::dfal_cond_s     condAsync,
  input  wire logic                     protoDone,
  input  wire logic                     protoFail,
  input  wire logic                     shadowValid,
  input  wire logic [`DFAL_CW_W-1:0]    shadowWord,
  input  wire logic                     nvmValid,
  input  wire logic [`DFAL_CW_W-1:0]    nvmWord,
  input  wire logic                     nvmDone,
  input  wire logic                     txOscDiv,
  input  wire logic                     selectPinIn,
  input  wire dfal_pkg::dfal_hs_s       hsIn,
  output dfal_pkg::dfal_hs_s            hsOut,
  output logic [`DFAL_NFLAGS-1:0]       flags,
  output logic                          alertPinOut,
  output logic                          alertPinOe,
  output logic [`DFAL_ADDR_W-1:0]       slaveAddr,
  output logic                          writeLocked,
  output logic                          writeRejected,
  output logic [`DFAL_OSC_W-1:0]        oscFreq,
  output logic                          startupDone,
  output logic                          shadowDataValid,
  output logic [`DFAL_DW-1:0]           shadowData,
  output logic                          nvmDataValid,
  output logic [`DFAL_DW-1:0]           nvmData
);
  import dfal_pkg::*;

  // Gate length in cycles; a parameter so a bench may pick another.
  parameter int GATE_CYC = `DFAL_GATE_CYC;

  // Static flags are sticky until reset; the rest follow their cause, the memory single-error flag only during start-up.
  localparam logic [`DFAL_NFLAGS-1:0] STATIC_MASK =
    (14'h0001 << `DFAL_F_SH_DED) |
    (14'h0001 << `DFAL_F_NVM_DED) |
    (14'h0001 << `DFAL_F_WDOG);

  dfal_cfg_s   cfg_reg;          // Active configuration.
  dfal_phase_e phase_reg;        // Start-up check or normal run.
  dfal_cond_s  condMeta_reg;     // First synchroniser stage.
  dfal_cond_s  cond_reg;         // Synchronised fault levels.
  logic [2:0]  oscSync_reg;      // Oscillator sampler and edge stage.
  logic [1:0]  selSync_reg;      // Select pin synchroniser.
  logic [`DFAL_NFLAGS-1:0] flags_next;
  logic        protoErr_reg;     // Last transfer failed.
  logic        shSed_reg;        // Last shadow word had one bad bit.
  logic        nvmSed_reg;       // Last memory word had one bad bit.
  logic [`DFAL_WD_W-1:0] wdLoad_reg;  // Watchdog reload value.
  logic [`DFAL_WD_W-1:0] wdCount_reg; // Watchdog down counter.
  logic        wdExpire;         // One-cycle watchdog expiry.
  logic [15:0] gate_reg;         // Gate time counter.
  logic [`DFAL_OSC_W-1:0] edgeCount_reg; // Edges within the gate.
  logic        gateEnd;          // Gate closes this cycle.
  logic        oscEdge;          // Rising edge of the oscillator.
  logic        oscOut_reg;       // Measured value out of range.
  logic        oscStuck_reg;     // No edge during the last gate.
  logic        alertNow;         // Some enabled flag is set.
  logic        shSed;
  logic        shDed;
  logic        nvmSed;
  logic        nvmDed;

  // Shadow register bank words are checked all the time.
  dfal_secded u_shadow_ecc (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .wordValid (shadowValid),
    .codeWord  (shadowWord),
    .dataValid (shadowDataValid),
    .dataOut   (shadowData),
    .singleErr (shSed),
    .doubleErr (shDed)
  );

  // Memory words are only checked while start-up reads them.
  dfal_secded u_nvm_ecc (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .wordValid (nvmValid && (phase_reg == DFAL_ST_CHECK)),
    .codeWord  (nvmWord),
    .dataValid (nvmDataValid),
    .dataOut   (nvmData),
    .singleErr (nvmSed),
    .doubleErr (nvmDed)
  );

  // Two-stage synchronisers for everything that arrives from pins.
  // Logic never reads the first stage.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      condMeta_reg <= '0;
      cond_reg     <= '0;
      oscSync_reg  <= 3'h0;
      selSync_reg  <= 2'h0;
    end else begin
      condMeta_reg <= condAsync;
      cond_reg     <= condMeta_reg;
      oscSync_reg  <= {oscSync_reg[1:0], txOscDiv};
      selSync_reg  <= {selSync_reg[0], selectPinIn};
    end
  end

  // Configuration writes. Once the lock bit is in, every later write
  // is refused and reported; only reset unlocks.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg       <= '0;
      writeRejected <= 1'b0;
    end else begin
      writeRejected <= 1'b0;
      if (cfgWrite || wdWrite) begin
        if (cfg_reg.writeLock) begin
          writeRejected <= 1'b1;                       // [RL4]
        end else if (cfgWrite) begin
          cfg_reg <= cfgData;
        end
      end
    end
  end

  // Start-up phase: memory words are checked until the loader reports
  // the last one; afterwards the memory flags are frozen.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= DFAL_ST_CHECK;
    end else begin
      case (phase_reg)
        DFAL_ST_CHECK: begin
          if (nvmDone) begin
            phase_reg <= DFAL_ST_RUN;                  // [RL11]
          end
        end
        DFAL_ST_RUN: begin
          phase_reg <= DFAL_ST_RUN;
        end
        default: begin
          phase_reg <= DFAL_ST_CHECK;
        end
      endcase
    end
  end

  // Event-type temporary causes. A failure sets the cause and a clean
  // result clears it; a failure in the same cycle wins.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      protoErr_reg <= 1'b0;
      shSed_reg    <= 1'b0;
      nvmSed_reg   <= 1'b0;
    end else begin
      if (protoFail) begin
        protoErr_reg <= 1'b1;                          // [RL13]
      end else if (protoDone) begin
        protoErr_reg <= 1'b0;                          // [RL10]
      end
      if (shadowDataValid) begin
        shSed_reg <= shSed;                            // [RL15]
      end
      if (nvmDataValid) begin
        nvmSed_reg <= nvmSed;                          // [RL17]
      end
    end
  end

  // Watchdog: a nonzero write loads and starts it, zero stops it.
  // Each expiry raises a one-cycle event and reloads.
  assign wdExpire = (wdCount_reg == 16'h0001);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdLoad_reg  <= `DFAL_WD_RST;
      wdCount_reg <= `DFAL_WD_RST;
    end else begin
      if (wdWrite && !cfg_reg.writeLock) begin
        wdLoad_reg  <= wdValue;
        wdCount_reg <= wdValue;                        // [RL22]
      end else if (wdExpire) begin
        wdCount_reg <= wdLoad_reg;                     // [RL22]
      end else if (wdCount_reg != `DFAL_WD_RST) begin
        wdCount_reg <= wdCount_reg - 16'h0001;
      end
    end
  end

  // Oscillator monitor: rising edges of the divided transmitter
  // oscillator are counted over a fixed gate. The count is the
  // frequency value; an empty gate means the oscillator stopped.
  // A gate of GATE_CYC cycles resolves the frequency only to one
  // edge, which is enough for a coarse window alarm.
  assign oscEdge = oscSync_reg[1] && !oscSync_reg[2];
  assign gateEnd = (gate_reg == 16'(GATE_CYC - 1));

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gate_reg      <= 16'h0000;
      edgeCount_reg <= `DFAL_OSC_RST;
      oscFreq       <= `DFAL_OSC_RST;
      oscOut_reg    <= 1'b0;
      oscStuck_reg  <= 1'b0;
    end else begin
      if (gateEnd) begin
        gate_reg      <= 16'h0000;
        edgeCount_reg <= `DFAL_OSC_RST;
        oscFreq       <= edgeCount_reg;
        oscOut_reg    <= (edgeCount_reg < cfg_reg.oscLow) ||
                         (edgeCount_reg > cfg_reg.oscHigh); // [RL18]
        oscStuck_reg  <= (edgeCount_reg == `DFAL_OSC_RST);  // [RL19]
      end else begin
        gate_reg <= gate_reg + 16'h0001;
        if (oscEdge && (edgeCount_reg != {`DFAL_OSC_W{1'b1}})) begin
          edgeCount_reg <= edgeCount_reg + 12'h001;
        end
      end
    end
  end

  // Next flag value: each check drives its own bit, except the analog supply
  // and both pin over-voltage checks, which share one. Start-up flags
  // only move while the memory is being checked.
  always_comb begin
    flags_next = flags & STATIC_MASK;
    flags_next[`DFAL_F_OVP]     = cond_reg.ovp;            // [RL12]
    flags_next[`DFAL_F_UVP]     = cond_reg.uvp;            // [RL12]
    flags_next[`DFAL_F_DATA]    = cond_reg.dataFail;       // [RL5]
    flags_next[`DFAL_F_PROTO]   = protoErr_reg || protoFail; // [RL13]
    flags_next[`DFAL_F_SH_SED]  = shSed_reg;               // [RL15]
    flags_next[`DFAL_F_NVM_SED] = flags[`DFAL_F_NVM_SED];
    if (phase_reg == DFAL_ST_CHECK) begin
      flags_next[`DFAL_F_NVM_SED] = nvmSed_reg;            // [RL17]
    end
    flags_next[`DFAL_F_OSC_RNG] = oscOut_reg;              // [RL18]
    flags_next[`DFAL_F_OSC_STK] = oscStuck_reg;            // [RL19]
    flags_next[`DFAL_F_INTERNAL_ANALOG_SUPPLY]    = cond_reg.vddaLow ||
                                  cond_reg.alertPinOv ||
                                  cond_reg.dataPinOv;      // [RL20]
    flags_next[`DFAL_F_LOWAMP]  = cond_reg.lowAmp &&
                                  cfg_reg.incrMode;        // [RL21]
    flags_next[`DFAL_F_BUS]     = cond_reg.busFail;        // [RL5]
    // Static flags: set by their event, never cleared here.
    if (shDed) begin
      flags_next[`DFAL_F_SH_DED] = 1'b1;                   // [RL14]
    end
    if (nvmDed) begin
      flags_next[`DFAL_F_NVM_DED] = 1'b1;                  // [RL16]
    end
    if (wdExpire) begin
      flags_next[`DFAL_F_WDOG] = 1'b1;                     // [RL22]
    end
  end

  // Flag register. Reset is the only thing that clears static flags.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags <= `DFAL_FLAGS_RST;                            // [RL9]
    end else begin
      flags <= flags_next;                                 // [RL10]
    end
  end

  // Alert condition from the enabled flags only.
  assign alertNow = |(flags_next & cfg_reg.irqEnable);     // [RL6]

  // Alert pin: open drain, pulled low while an enabled flag is set.
  // Outside interrupt mode the pin is an address select input and
  // stays released.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      alertPinOut <= 1'b1;
      alertPinOe  <= 1'b1;
    end else begin
      alertPinOut <= !(cfg_reg.i2cIrqMode && alertNow);
      alertPinOe  <= !(cfg_reg.i2cIrqMode && alertNow);    // [RL1] [RL23]
    end
  end

  // Slave address: programmed, with the low bit taken from the select
  // pin when the pin is used for address selection.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      slaveAddr <= `DFAL_ADDR_RST;
    end else if (cfg_reg.i2cIrqMode) begin
      slaveAddr <= cfg_reg.slaveAddr;                      // [RL2]
    end else begin
      slaveAddr <= {cfg_reg.slaveAddr[`DFAL_ADDR_W-1:1],
                    selSync_reg[1]};                       // [RL2]
    end
  end

  // High-speed outputs: pass the position signals, or force all four
  // to the chosen level while an alert is active and forcing is on.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hsOut <= '0;
    end else if (cfg_reg.hsDiagEn && alertNow) begin
      hsOut <= {4{cfg_reg.hsDiagHigh}};                    // [RL7] [RL8]
    end else begin
      hsOut <= hsIn;
    end
  end

  // Status outputs.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      writeLocked <= 1'b0;
      startupDone <= 1'b0;
    end else begin
      writeLocked <= cfg_reg.writeLock;                    // [RL4]
      startupDone <= (phase_reg == DFAL_ST_RUN);
    end
  end

endmodule

/* File: logic/dfal_map.svh */
/*
  Constants of the diagnostic flag and alert block: flag positions,
  reset values and timing counts.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef DFAL_MAP_SVH
`define DFAL_MAP_SVH

// Number of diagnostic flags and their bit positions.
`define DFAL_NFLAGS     14
`define DFAL_F_OVP      0
`define DFAL_F_UVP      1
`define DFAL_F_DATA     2
`define DFAL_F_PROTO    3
`define DFAL_F_SH_DED   4
`define DFAL_F_SH_SED   5
`define DFAL_F_NVM_DED  6
`define DFAL_F_NVM_SED  7
`define DFAL_F_OSC_RNG  8
`define DFAL_F_OSC_STK  9
`define DFAL_F_INTERNAL_ANALOG_SUPPLY     10
`define DFAL_F_LOWAMP   11
`define DFAL_F_BUS      12
`define DFAL_F_WDOG     13

// Reset values.
`define DFAL_FLAGS_RST  14'h0000
`define DFAL_ADDR_RST   7'h00
`define DFAL_WD_RST     16'h0000
`define DFAL_OSC_RST    12'h000

// Field widths.
`define DFAL_WD_W       16
`define DFAL_OSC_W      12
`define DFAL_ADDR_W     7
`define DFAL_CW_W       13
`define DFAL_DW         8

// Oscillator gate time in ns, clock period in ns, and gate in cycles.
`define DFAL_GATE_NS    10000
`define DFAL_CLK_NS     40
`define DFAL_GATE_CYC   ((`DFAL_GATE_NS + `DFAL_CLK_NS - 1) / `DFAL_CLK_NS)

`endif

/* File: logic/dfal_pkg.sv */
/*
  Types of the diagnostic flag and alert block.
  Assumes dfal_map.svh is on the include path.
*/
`include "dfal_map.svh"

package dfal_pkg;

  // Configuration written by the host through the serial port.
  typedef struct packed {
    logic [`DFAL_NFLAGS-1:0] irqEnable;   // Per-flag alert enable.
    logic                    hsDiagEn;    // Force outputs on alert.
    logic                    hsDiagHigh;  // Forced level is high.
    logic                    i2cIrqMode;  // Select pin acts as alert.
    logic                    incrMode;    // Incremental output mode.
    logic [`DFAL_ADDR_W-1:0] slaveAddr;   // Programmed slave address.
    logic [`DFAL_OSC_W-1:0]  oscLow;      // Lowest good frequency.
    logic [`DFAL_OSC_W-1:0]  oscHigh;     // Highest good frequency.
    logic                    writeLock;   // Makes access read-only.
  } dfal_cfg_s;

  // Raw fault levels from the analog checks, asynchronous.
  typedef struct packed {
    logic ovp;          // Supply above nominal plus 10 percent.
    logic uvp;          // Supply below nominal minus 10 percent.
    logic dataFail;     // Internal data access failure.
    logic busFail;      // Internal bus failure.
    logic vddaLow;      // Internal analog supply under limit.
    logic alertPinOv;   // Over-voltage on the select or alert pin.
    logic dataPinOv;    // Over-voltage on the serial data pin.
    logic lowAmp;       // Signal amplitude below minimum.
  } dfal_cond_s;

  // The four high-speed sine and cosine outputs.
  typedef struct packed {
    logic sinePos;
    logic sineNeg;
    logic cosinePos;
    logic cosineNeg;
  } dfal_hs_s;

  // Start-up phase: memory words checked, then normal run.
  typedef enum logic [1:0] {
    DFAL_ST_CHECK = 2'b01,
    DFAL_ST_RUN   = 2'b10
  } dfal_phase_e;

endpackage

/* File: logic/dfal_secded.sv */
/*
  Single-error-correcting, double-error-detecting decoder for one
  8-bit word held in a 13-bit code word (bit 0 overall parity, bits
  1..12 a Hamming code with check bits at 1, 2, 4 and 8).
  Assumes code words arrive on ref_clk with a one-cycle valid strobe.
*/
`include "dfal_map.svh"

module dfal_secded (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  input  wire logic                   wordValid,
  input  wire logic [`DFAL_CW_W-1:0]  codeWord,
  output logic                        dataValid,
  output logic      [`DFAL_DW-1:0]    dataOut,
  output logic                        singleErr,
  output logic                        doubleErr
);
  import dfal_pkg::*;

  // Syndrome of the Hamming part: XOR of the positions of set bits.
  function automatic logic [3:0] syndrome(input logic [12:0] cw);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 1; i < 13; i++) begin
      if (cw[i]) begin
        s = s ^ 4'(i);
      end
    end
    return s;
  endfunction

  logic [3:0]  syn;       // Position of a single flipped bit.
  logic        parOdd;    // Overall parity broken.
  logic [12:0] fixedWord; // Code word after correction.

  // Decode: odd parity means one error, correctable; even parity with
  // a nonzero syndrome means two errors, which cannot be repaired.
  always_comb begin
    syn       = syndrome(codeWord);
    parOdd    = ^codeWord;
    fixedWord = codeWord;
    if (parOdd && (syn != 4'h0) && (syn < 4'hd)) begin
      fixedWord[syn] = ~codeWord[syn];
    end
  end

  // Register the corrected data and the error strobes together.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dataValid <= 1'b0;
      dataOut   <= 8'h00;
      singleErr <= 1'b0;
      doubleErr <= 1'b0;
    end else begin
      dataValid <= wordValid;
      dataOut   <= {fixedWord[12:9], fixedWord[7:5], fixedWord[3]};
      singleErr <= wordValid && parOdd;
      doubleErr <= wordValid && !parOdd && (syn != 4'h0);
    end
  end

endmodule

/* File: sim/dfal_alert_sva.sv */
/*
  Port assertions of the diagnostic flag and alert block.
  Assumes it is bound to dfal_alert_top and sees only its ports.
*/
`include "dfal_map.svh"
module dfal_alert_sva
  import dfal_pkg::*;
(
  input wire logic                    ref_clk,
  input wire logic                    resetn,
  input wire logic                    cfgWrite,
  input wire logic                    wdWrite,
  input wire dfal_pkg::dfal_cond_s    condAsync,
  input wire logic                    protoFail,
  input wire logic                    shadowValid,
  input wire dfal_pkg::dfal_hs_s      hsIn,
  input wire dfal_pkg::dfal_hs_s      hsOut,
  input wire logic [`DFAL_NFLAGS-1:0] flags,
  input wire logic                    alertPinOut,
  input wire logic                    alertPinOe,
  input wire logic                    writeLocked,
  input wire logic                    writeRejected,
  input wire logic                    startupDone,
  input wire logic                    shadowDataValid,
  input wire logic                    nvmDataValid
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  lock_reject_a: assert property (
    (cfgWrite || wdWrite) && writeLocked |-> ##[1:2] writeRejected)
    else $error("write taken while locked");
  lock_hold_a: assert property (
    writeLocked |=> writeLocked) else $error("lock dropped");
  // The pin is driven only as a low level and only for a raised flag.
  alert_drive_a: assert property (
    !alertPinOe |-> !alertPinOut && (flags != 14'h0000))
    else $error("alert driven with no flag");
  // Static bits may rise but never fall outside reset.
  static_hold_a: assert property (
    (flags & $past(flags) & 14'h2050) == ($past(flags) & 14'h2050))
    else $error("static flag cleared");
  proto_set_a: assert property (
    protoFail |=> flags[3]) else $error("protocol flag missing");
  ovp_set_a: assert property (
    condAsync.ovp [*3] |=> flags[0]) else $error("ovp flag missing");
  uvp_clear_a: assert property (
    !condAsync.uvp [*3] |=> !flags[1]) else $error("uvp flag stuck");
  hs_pass_a: assert property (
    flags == 14'h0000 |-> hsOut == $past(hsIn))
    else $error("outputs forced with no flag");
  shadow_out_a: assert property (
    shadowValid |=> shadowDataValid) else $error("no corrected data");
  nvm_stop_a: assert property (
    startupDone |-> !nvmDataValid) else $error("memory check after start");
endmodule

// Every checker port carries the name of the top port that it watches.
bind dfal_alert_top dfal_alert_sva i_dfal_alert_sva (.*);

/* File: sim/dfal_osc_model.sv */
/*
  Transmitter oscillator seen through its divider, 320 ns period.
  Assumes the bench starts and stops it through run.
*/
module dfal_osc_model (
  input  wire logic run,
  output logic      txOscDiv
);
  timeunit 1ns;
  timeprecision 1ps;
  // A stopped oscillator rests low; the odd start keeps phase apart.
  initial begin
    txOscDiv = 1'b0;
    #7;
    forever begin
      #160;
      txOscDiv = run ? ~txOscDiv : 1'b0;
    end
  end
endmodule

/* File: sim/tb.sv */
/*
  Self-checking bench of the diagnostic flag and alert block.
  Assumes the design, the checker and the oscillator model compile first.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dfal_pkg::*;
  localparam int GATE = 40; // Short gate: five divided periods.
  logic       ref_clk, resetn, cfgWrite, wdWrite, protoDone, protoFail;
  logic       shadowValid, nvmValid, nvmDone, selectPinIn, oscRun, r;
  logic       txOscDiv, writeLocked, writeRejected, startupDone;
  logic       shadowDataValid, nvmDataValid, alertPinOut, alertPinOe;
  dfal_cfg_s  cfg;
  dfal_cond_s condAsync;
  dfal_hs_s   hsIn, hsOut;
  logic [15:0] wdValue;
  logic [12:0] shadowWord, nvmWord;
  logic [13:0] flags;
  logic [6:0]  slaveAddr;
  logic [11:0] oscFreq;
  logic [7:0]  shadowData, nvmData;
  logic [31:0] rnd;       // Random source state.
  logic [1:0]  dedSeen;   // Model of the sticky double-error flags.
  logic [7:0]  expQ[$];   // Model of corrected data words.
  int          checksDone, miscompares;
  int          posTab[8] = '{0, 1, 2, 12, 10, 10, 10, 11};

  // Bench signals share the port names; only the config is renamed.
  dfal_alert_top #(.GATE_CYC(GATE)) i_dfal_alert_top (.cfgData(cfg), .*);
  dfal_osc_model i_dfal_osc_model (.run(oscRun), .txOscDiv(txOscDiv));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Cuts a hang short; the run needs well under 3000 cycles.
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Builds an even-parity extended Hamming word around one byte.
  function automatic logic [12:0] enc(input logic [7:0] d);
    logic [12:0] c;
    c = 13'h0000;
    {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]} = d;
    for (int k = 0; k < 4; k++) begin
      for (int p = 3; p < 13; p++) begin
        if (p[k] && p != (1 << k)) c[1 << k] ^= c[p];
      end
    end
    c[0] = ^c[12:1];
    return c;
  endfunction

  // Inputs move 2 ns after the edge; hsIn is refreshed every cycle.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      #2;
      rnd = nxt(rnd);
      hsIn = rnd[3:0];
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wcfg();
    cfgWrite = 1'b1;
    tick(1);
    cfgWrite = 1'b0;
    tick(1);
  endtask

  // One code word with nerr flipped bits; the single-error flag is
  // registered twice after the corrected data, so flags are read then.
  task automatic ecc(input bit nvm, input int nerr);
    logic [12:0] c;
    int          a, b;
    a = rnd[19:16] % 13;
    b = (a + 1 + rnd[23:20] % 12) % 13;
    c = enc(rnd[15:8]);
    expQ.push_back(rnd[15:8]);
    if (nerr > 0) c[a] = ~c[a];
    if (nerr > 1) c[b] = ~c[b];
    dedSeen[nvm] |= (nerr == 2);
    nvmValid = nvm;
    shadowValid = !nvm;
    nvmWord = c;
    shadowWord = c;
    tick(1);
    nvmValid = 1'b0;
    shadowValid = 1'b0;
    chk(nvm ? nvmDataValid : shadowDataValid, 1);
    if (nerr < 2) chk(nvm ? nvmData : shadowData, expQ[0]);
    void'(expQ.pop_front());
    tick(2);
    chk(flags[nvm ? 7 : 5], nerr == 1);
    chk(flags[nvm ? 6 : 4], dedSeen[nvm]);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rnd = 32'hf8b47972;
    {checksDone, miscompares, dedSeen} = '0;
    {resetn, cfgWrite, wdWrite, protoDone, protoFail} = '0;
    {shadowValid, nvmValid, nvmDone, wdValue, shadowWord, nvmWord} = '0;
    {hsIn, condAsync, cfg} = '0;
    selectPinIn = 1'b1;
    oscRun = 1'b1;
    repeat (16) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    tick(4);
    chk({flags, alertPinOe, slaveAddr}, {14'h0000, 1'b1, 7'h01});
    cfg.irqEnable = 14'h0008;
    {cfg.hsDiagEn, cfg.i2cIrqMode, cfg.incrMode} = 3'h7;
    {cfg.slaveAddr, cfg.oscLow, cfg.oscHigh} = {7'h5a, 12'h003, 12'h007};
    wcfg();
    chk(slaveAddr, 7'h5a);
    for (int i = 0; i < 4; i++) ecc(1, i % 3);
    nvmDone = 1'b1;
    tick(1);
    nvmDone = 1'b0;
    tick(2);
    chk(startupDone, 1);
    for (int i = 0; i < 7; i++) ecc(0, i % 3);
    $display("test ecc done");
    // Forced high, forced low, then the alert enable taken away.
    for (int j = 0; j < 3; j++) begin
      cfg.hsDiagHigh = (j == 0);
      cfg.irqEnable = (j < 2) ? 14'h0008 : 14'h0000;
      wcfg();
      protoFail = 1'b1;
      tick(1);
      protoFail = 1'b0;
      chk(flags[3], 1);
      chk(alertPinOe, j == 2);
      if (j < 2) chk(hsOut, {4{j == 0}});
      protoDone = 1'b1;
      tick(1);
      protoDone = 1'b0;
      tick(2);
      chk({flags[3], alertPinOe}, 2'b01);
    end
    $display("test alert done");
    for (int i = 0; i < 8; i++) begin
      condAsync = 8'h80 >> i;
      tick(4);
      chk(flags & 14'h1c07, 14'h0001 << posTab[i]);
    end
    cfg.incrMode = 1'b0;
    wcfg();
    tick(4);
    chk(flags[11], 0);
    condAsync = '0;
    tick(4);
    chk(flags & 14'h1c07, 14'h0000);
    $display("test conditions done");
    tick(2 * GATE + 4);
    chk(oscFreq >= 12'h004 && oscFreq <= 12'h006, 1);
    chk(flags[9:8], 2'b00);
    cfg.oscHigh = 12'h002;
    wcfg();
    tick(2 * GATE + 4);
    chk(flags[9:8], 2'b01);
    oscRun = 1'b0;
    tick(2 * GATE + 4);
    chk({oscFreq, flags[9]}, 13'h0001);
    oscRun = 1'b1;
    cfg.oscHigh = 12'h007;
    wcfg();
    tick(2 * GATE + 4);
    chk(flags[9:8], 2'b00);
    $display("test oscillator done");
    wdValue = 16'h0006;
    wdWrite = 1'b1;
    tick(1);
    wdWrite = 1'b0;
    tick(4);
    chk(flags[13], 0);
    tick(4);
    chk(flags[13], 1);
    wdValue = 16'h0000;
    wdWrite = 1'b1;
    tick(1);
    wdWrite = 1'b0;
    tick(20);
    chk(flags[13], 1);
    $display("test watchdog done");
    cfg.writeLock = 1'b1;
    wcfg();
    tick(1);
    chk(writeLocked, 1);
    cfg.slaveAddr = 7'h11;
    for (int k = 0; k < 2; k++) begin
      cfgWrite = (k == 0);
      wdWrite = (k == 1);
      tick(1);
      {cfgWrite, wdWrite} = 2'b00;
      r = writeRejected;
      tick(1);
      chk(r | writeRejected, 1);
    end
    chk(slaveAddr, 7'h5a);
    $display("test lock done");
    stop_test();
  end
endmodule
